// *** rtl/bpdcr_consts.vh ***
// Register offsets, field positions, reset values, command codes and timing counts.
`ifndef BPDCR_CONSTS_VH
`define BPDCR_CONSTS_VH

`define BPDCR_OFF_CTRL        8'h00
`define BPDCR_OFF_STATUS      8'h04
`define BPDCR_OFF_IO_BASE     8'h08
`define BPDCR_OFF_IO_LIMIT    8'h0c
`define BPDCR_OFF_MEM_BASE    8'h10
`define BPDCR_OFF_MEM_LIMIT   8'h14
`define BPDCR_OFF_MMIO_BASE   8'h18
`define BPDCR_OFF_MMIO_LIMIT  8'h1c
`define BPDCR_OFF_BUS_NUM     8'h20
`define BPDCR_OFF_FUNC_MASK   8'h24
`define BPDCR_OFF_LAST_DEC    8'h28

`define BPDCR_CTRL_CHIP_RST   0
`define BPDCR_CTRL_SEC_RST    1
`define BPDCR_STAT_MASK_DONE  2
`define BPDCR_STAT_EXIT_BUSY  3

`define BPDCR_RST_WORD        32'h0000_0000
`define BPDCR_RST_LIMIT       32'h0000_0000
`define BPDCR_RST_FUNC_MASK   8'h01

`define BPDCR_CMD_INT_ACK     4'h0
`define BPDCR_CMD_SPECIAL     4'h1
`define BPDCR_CMD_IO_RD       4'h2
`define BPDCR_CMD_IO_WR       4'h3
`define BPDCR_CMD_MEM_RD      4'h6
`define BPDCR_CMD_MEM_WR      4'h7
`define BPDCR_CMD_CFG_RD      4'ha
`define BPDCR_CMD_CFG_WR      4'hb
`define BPDCR_CMD_MEM_RD_MUL  4'hc
`define BPDCR_CMD_DAC         4'hd
`define BPDCR_CMD_MEM_RD_LINE 4'he
`define BPDCR_CMD_MEM_WR_INV  4'hf

`define BPDCR_CFG_TYPE0       2'h0
`define BPDCR_CFG_TYPE1       2'h1
`define BPDCR_SPC_DEVICE      5'h1f
`define BPDCR_SPC_FUNCTION    3'h7

`define BPDCR_CLK_PERIOD_NS   100
`define BPDCR_EXIT_MAX_CYC    20
`define BPDCR_EXIT_CYC        5'd16

`endif

// *** rtl/bpdcr_decode.v ***
// Primary-side command decode and software chip reset of a two-port bridge.
//
// Design decisions made here: the APB interface to the registers and the address map.
`include "bpdcr_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module bpdcr_decode #(
    parameter ADDR_W = 32
) (
    input  wire              clock,
    input  wire              nrst,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [7:0]        paddr,
    input  wire [31:0]       pwdata,
    output reg               pready,
    output reg  [31:0]       prdata,
    output reg               pslverr,
    input  wire              req_valid,
    input  wire [3:0]        primary_command_lanes,
    input  wire [ADDR_W-1:0] req_addr,
    input  wire              req_idsel,
    input  wire              clock_mask_done,
    output reg               dec_done,
    output reg               dec_claim,
    output reg               dec_internal,
    output reg               fwd_valid,
    output reg  [3:0]        fwd_cmd,
    output reg  [ADDR_W-1:0] fwd_addr,
    output reg               pri_out_en,
    output reg               sec_ctl_out_en,
    output reg               sec_bus_rst_n,
    output reg               buf_flush,
    output reg               chip_rst_active
);

    localparam EXIT_CNT_W = 5;

    // Exit count must not exceed the documented bound; 16 leaves margin for the output stage.
    localparam [EXIT_CNT_W-1:0] EXIT_CYC = `BPDCR_EXIT_CYC;

    reg                  chip_rst;
    reg                  sec_rst;
    reg                  mask_done;
    reg [EXIT_CNT_W-1:0] exit_cnt;
    reg                  exit_busy;
    reg [31:0]           io_base;
    reg [31:0]           io_limit;
    reg [31:0]           mem_base;
    reg [31:0]           mem_limit;
    reg [31:0]           mmio_base;
    reg [31:0]           mmio_limit;
    reg [7:0]            sec_bus;
    reg [7:0]            sub_bus;
    reg [7:0]            func_mask;
    reg [7:0]            last_dec;

    wire apb_access = psel && penable && !pready;
    wire apb_wr     = apb_access && pwrite;
    wire ctrl_wr    = apb_wr && (paddr == `BPDCR_OFF_CTRL);
    wire chip_req   = ctrl_wr && pwdata[`BPDCR_CTRL_CHIP_RST];
    wire soft_clr   = chip_req || chip_rst;
    // While a chip reset runs, the secondary bus also waits for the clock mask to arrive.
    wire sec_hold   = sec_rst || chip_req
                   || (chip_rst && !mask_done && !clock_mask_done);
    wire addr_ok    = (paddr == `BPDCR_OFF_CTRL) || (paddr == `BPDCR_OFF_STATUS)
                   || (paddr == `BPDCR_OFF_IO_BASE) || (paddr == `BPDCR_OFF_IO_LIMIT)
                   || (paddr == `BPDCR_OFF_MEM_BASE) || (paddr == `BPDCR_OFF_MEM_LIMIT)
                   || (paddr == `BPDCR_OFF_MMIO_BASE) || (paddr == `BPDCR_OFF_MMIO_LIMIT)
                   || (paddr == `BPDCR_OFF_BUS_NUM) || (paddr == `BPDCR_OFF_FUNC_MASK)
                   || (paddr == `BPDCR_OFF_LAST_DEC);

    // Control, chip reset sequencing and secondary reset.
    always @(posedge clock) begin
        if (!nrst) begin
            chip_rst  <= 1'b0;
            sec_rst   <= 1'b0;
            mask_done <= 1'b0;
            exit_cnt  <= {EXIT_CNT_W{1'b0}};
            exit_busy <= 1'b0;
        end else if (chip_req && !chip_rst) begin
            chip_rst  <= 1'b1;
            sec_rst   <= 1'b1;
            mask_done <= 1'b0;
            exit_cnt  <= {EXIT_CNT_W{1'b0}};
            exit_busy <= 1'b0;
        end else begin
            if (ctrl_wr && !pwdata[`BPDCR_CTRL_SEC_RST]) begin
                sec_rst <= 1'b0;
            end else if (ctrl_wr && !chip_rst) begin
                sec_rst <= 1'b1;
            end
            if (chip_rst && clock_mask_done) begin
                mask_done <= 1'b1;
            end
            // Release only once the bit is clear and the clock mask is in.
            if (chip_rst && !exit_busy && !sec_rst && (mask_done || clock_mask_done)) begin
                exit_busy <= 1'b1;
                exit_cnt  <= {EXIT_CNT_W{1'b0}};
            end else if (exit_busy) begin
                if (exit_cnt == EXIT_CYC - 1'b1) begin
                    chip_rst  <= 1'b0;
                    exit_busy <= 1'b0;
                    mask_done <= 1'b0;
                end else begin
                    exit_cnt <= exit_cnt + 1'b1;
                end
            end
        end
    end

    // Window and bus-number registers; a chip reset puts them back to defaults.
    always @(posedge clock) begin
        if (!nrst || soft_clr) begin
            io_base    <= `BPDCR_RST_WORD;
            io_limit   <= `BPDCR_RST_LIMIT;
            mem_base   <= `BPDCR_RST_WORD;
            mem_limit  <= `BPDCR_RST_LIMIT;
            mmio_base  <= `BPDCR_RST_WORD;
            mmio_limit <= `BPDCR_RST_LIMIT;
            sec_bus    <= 8'h00;
            sub_bus    <= 8'h00;
            func_mask  <= `BPDCR_RST_FUNC_MASK;
        end else if (apb_wr) begin
            case (paddr)
                `BPDCR_OFF_IO_BASE: begin
                    io_base <= pwdata;
                end
                `BPDCR_OFF_IO_LIMIT: begin
                    io_limit <= pwdata;
                end
                `BPDCR_OFF_MEM_BASE: begin
                    mem_base <= pwdata;
                end
                `BPDCR_OFF_MEM_LIMIT: begin
                    mem_limit <= pwdata;
                end
                `BPDCR_OFF_MMIO_BASE: begin
                    mmio_base <= pwdata;
                end
                `BPDCR_OFF_MMIO_LIMIT: begin
                    mmio_limit <= pwdata;
                end
                `BPDCR_OFF_BUS_NUM: begin
                    sec_bus <= pwdata[7:0];
                    sub_bus <= pwdata[15:8];
                end
                `BPDCR_OFF_FUNC_MASK: begin
                    func_mask <= pwdata[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    // APB slave with one wait state so every answer comes from a flip-flop.
    always @(posedge clock) begin
        if (!nrst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= apb_access;
            pslverr <= apb_access && !addr_ok;
            prdata  <= 32'h0000_0000;
            if (apb_access && !pwrite) begin
                case (paddr)
                    `BPDCR_OFF_CTRL: begin
                        prdata <= {30'h0, sec_rst, chip_rst};
                    end
                    `BPDCR_OFF_STATUS: begin
                        prdata <= {28'h000_0000, exit_busy, mask_done, sec_rst, chip_rst};
                    end
                    `BPDCR_OFF_IO_BASE: begin
                        prdata <= io_base;
                    end
                    `BPDCR_OFF_IO_LIMIT: begin
                        prdata <= io_limit;
                    end
                    `BPDCR_OFF_MEM_BASE: begin
                        prdata <= mem_base;
                    end
                    `BPDCR_OFF_MEM_LIMIT: begin
                        prdata <= mem_limit;
                    end
                    `BPDCR_OFF_MMIO_BASE: begin
                        prdata <= mmio_base;
                    end
                    `BPDCR_OFF_MMIO_LIMIT: begin
                        prdata <= mmio_limit;
                    end
                    `BPDCR_OFF_BUS_NUM: begin
                        prdata <= {16'h0000, sub_bus, sec_bus};
                    end
                    `BPDCR_OFF_FUNC_MASK: begin
                        prdata <= {24'h00_0000, func_mask};
                    end
                    `BPDCR_OFF_LAST_DEC: begin
                        prdata <= {24'h00_0000, last_dec};
                    end
                    default: begin
                        prdata <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // Combinational decode of one primary request.
    wire [31:0] a32      = req_addr[31:0];
    wire [1:0]  cfg_type = req_addr[1:0];
    wire [7:0]  tgt_bus  = req_addr[23:16];
    wire [4:0]  tgt_dev  = req_addr[15:11];
    wire [2:0]  tgt_fn   = req_addr[10:8];
    wire io_hit   = (a32 >= io_base) && (a32 <= io_limit);
    wire mem_hit  = ((a32 >= mem_base) && (a32 <= mem_limit))
                 || ((a32 >= mmio_base) && (a32 <= mmio_limit));
    wire on_sec   = (tgt_bus == sec_bus);
    wire on_sub   = (tgt_bus > sec_bus) && (tgt_bus <= sub_bus);
    wire spc_req  = (tgt_dev == `BPDCR_SPC_DEVICE) && (tgt_fn == `BPDCR_SPC_FUNCTION);

    reg              next_claim;
    reg              next_internal;
    reg              next_fwd;
    reg [3:0]        next_cmd;
    reg [ADDR_W-1:0] next_addr;

    always @* begin
        next_claim    = 1'b0;
        next_internal = 1'b0;
        next_fwd      = 1'b0;
        next_cmd      = primary_command_lanes;
        next_addr     = req_addr;
        case (primary_command_lanes)
            `BPDCR_CMD_IO_RD, `BPDCR_CMD_IO_WR: begin
                next_fwd = io_hit;
            end
            `BPDCR_CMD_MEM_RD, `BPDCR_CMD_MEM_WR: begin
                next_fwd = mem_hit;
            end
            `BPDCR_CMD_MEM_RD_MUL, `BPDCR_CMD_MEM_RD_LINE, `BPDCR_CMD_MEM_WR_INV: begin
                next_fwd = mem_hit;
            end
            `BPDCR_CMD_DAC: begin
                next_fwd = mem_hit;
            end
            `BPDCR_CMD_CFG_RD, `BPDCR_CMD_CFG_WR: begin
                if (cfg_type == `BPDCR_CFG_TYPE0) begin
                    // Type 0 is only ever an internal access, never passed on.
                    next_internal = req_idsel && func_mask[tgt_fn];
                end else if (cfg_type == `BPDCR_CFG_TYPE1) begin
                    if (on_sec) begin
                        next_fwd = 1'b1;
                        next_addr = {req_addr[ADDR_W-1:2], `BPDCR_CFG_TYPE0};
                        if ((primary_command_lanes == `BPDCR_CMD_CFG_WR) && spc_req) begin
                            next_cmd = `BPDCR_CMD_SPECIAL;
                        end
                    end else if (on_sub) begin
                        next_fwd = 1'b1;
                    end
                end
            end
            default: begin
                // Interrupt acknowledge, special cycle and reserved codes stay unclaimed.
                next_fwd = 1'b0;
            end
        endcase
        // Nothing is passed toward a secondary bus that is held in reset.
        if (sec_rst) begin
            next_fwd = 1'b0;
        end
        next_claim = next_fwd || next_internal;
    end

    // Registered decode answer; requests are dropped unanswered during chip reset.
    always @(posedge clock) begin
        if (!nrst || soft_clr) begin
            dec_done     <= 1'b0;
            dec_claim    <= 1'b0;
            dec_internal <= 1'b0;
            fwd_valid    <= 1'b0;
            fwd_cmd      <= 4'h0;
            fwd_addr     <= {ADDR_W{1'b0}};
            last_dec     <= 8'h00;
        end else if (req_valid) begin
            dec_done     <= 1'b1;
            dec_claim    <= next_claim;
            dec_internal <= next_internal;
            fwd_valid    <= next_fwd;
            fwd_cmd      <= next_fwd ? next_cmd : 4'h0;
            fwd_addr     <= next_fwd ? next_addr : {ADDR_W{1'b0}};
            last_dec     <= {next_cmd, 1'b0, next_internal, next_fwd, next_claim};
        end else begin
            dec_done  <= 1'b0;
            dec_claim <= 1'b0;
            fwd_valid <= 1'b0;
            if (sec_rst) begin
                fwd_cmd  <= 4'h0;
                fwd_addr <= {ADDR_W{1'b0}};
            end
        end
    end

    // Pin enables and reset outputs.
    always @(posedge clock) begin
        if (!nrst) begin
            pri_out_en      <= 1'b0;
            sec_ctl_out_en  <= 1'b0;
            sec_bus_rst_n   <= 1'b0;
            buf_flush       <= 1'b1;
            chip_rst_active <= 1'b0;
        end else begin
            pri_out_en      <= !soft_clr;
            sec_ctl_out_en  <= !soft_clr && !sec_rst;
            sec_bus_rst_n   <= !sec_hold;
            buf_flush       <= sec_hold;
            chip_rst_active <= chip_rst;
        end
    end

endmodule // bpdcr_decode

`default_nettype wire

// *** tb/bpdcr_props.sv ***
// Concurrent checks on the ports of the bridge decode block.
`include "bpdcr_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module bpdcr_props #(
    parameter ADDR_W = 32
) (
    input wire logic              clock,
    input wire logic              nrst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic              pready,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              req_valid,
    input wire logic [3:0]        primary_command_lanes,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic              clock_mask_done,
    input wire logic              dec_done,
    input wire logic              dec_claim,
    input wire logic              fwd_valid,
    input wire logic              pri_out_en,
    input wire logic              sec_ctl_out_en,
    input wire logic              sec_bus_rst_n,
    input wire logic              chip_rst_active
);
    wire ctl_wr  = psel && penable && pwrite && !pready && paddr == `BPDCR_OFF_CTRL;
    wire chip_wr = ctl_wr && pwdata[0];
    wire clr_wr  = ctl_wr && !pwdata[`BPDCR_CTRL_SEC_RST];
    reg  chip_wr_q;
    // The chip bit may lead its registered copy by an edge, so a request next to the write is left out.
    always @(posedge clock) chip_wr_q <= chip_wr;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence s_fresh_req;
        req_valid && !chip_rst_active && !chip_wr && !chip_wr_q;
    endsequence
    sequence s_held_reset;
        chip_rst_active [*2];
    endsequence
    a_answer_next: assert property (s_fresh_req |=> dec_done)
        else $error("decode request not answered");
    a_silent_reset: assert property (s_held_reset |-> !dec_done)
        else $error("answer during chip reset");
    a_ignore_codes: assert property (dec_done && $past(primary_command_lanes) inside
        {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9} |-> !dec_claim) else $error("ignored command claimed");
    a_fwd_claimed: assert property (fwd_valid |-> dec_done && dec_claim)
        else $error("forward without claim");
    a_type0_local: assert property (dec_done && $past(req_addr[1:0]) == 2'h0 &&
        $past(primary_command_lanes) inside {4'ha, 4'hb} |-> !fwd_valid) else $error("type 0 forwarded");
    a_outputs_off: assert property (s_held_reset |-> !pri_out_en && !sec_ctl_out_en)
        else $error("outputs driven in chip reset");
    a_sec_rst_set: assert property (chip_wr && !chip_rst_active |-> ##[1:2] !sec_bus_rst_n)
        else $error("secondary reset not driven");
    a_exit_bound: assert property (clr_wr && chip_rst_active && clock_mask_done
        |-> ##[1:21] !chip_rst_active) else $error("chip reset did not clear");
    a_no_fwd_sec: assert property (!sec_bus_rst_n [*2] |-> !fwd_valid)
        else $error("forward during secondary reset");
endmodule // bpdcr_props
bind bpdcr_decode bpdcr_props #(.ADDR_W(ADDR_W)) props_u (.clock(clock), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata),
    .req_valid(req_valid), .primary_command_lanes(primary_command_lanes), .req_addr(req_addr),
    .clock_mask_done(clock_mask_done), .dec_done(dec_done), .dec_claim(dec_claim),
    .fwd_valid(fwd_valid), .pri_out_en(pri_out_en), .sec_ctl_out_en(sec_ctl_out_en),
    .sec_bus_rst_n(sec_bus_rst_n), .chip_rst_active(chip_rst_active));
`default_nettype wire

// *** tb/bpdcr_host.sv ***
// Behavioural primary host that presents one decode request per go pulse.
`timescale 1ns/10ps
`default_nettype none
module bpdcr_host (
    input  wire logic        clock,
    input  wire logic        go,
    input  wire logic [3:0]  cmd,
    input  wire logic [31:0] addr,
    input  wire logic        idsel,
    output var  logic        req_valid,
    output var  logic [3:0]  primary_command_lanes,
    output var  logic [31:0] req_addr,
    output var  logic        req_idsel
);
    initial begin
        req_valid = 1'h0;
        primary_command_lanes = 4'h0;
        req_addr = 32'h0;
        req_idsel = 1'h0;
    end
    // Idle command and address lines toggle instead of holding, so a decoder that samples outside the request is caught.
    always @(posedge clock) begin
        req_valid <= go;
        primary_command_lanes <= go ? cmd : ~primary_command_lanes;
        req_addr <= go ? addr : ~req_addr;
        req_idsel <= go && idsel;
    end
endmodule // bpdcr_host
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the bridge decode and chip reset.
`include "bpdcr_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module tb;
    typedef struct packed {
        logic [3:0]  cmd;
        logic [31:0] addr;
        logic [2:0]  flags;
        logic [3:0]  fcmd;
    } bpdcr_row_t;
    logic        clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, go = 0, idsel = 0;
    logic        clock_mask_done = 0, pready, pslverr, req_valid, req_idsel, dec_done, dec_claim;
    logic        dec_internal, fwd_valid, pri_out_en, sec_ctl_out_en, sec_bus_rst_n, buf_flush;
    logic        chip_rst_active, err;
    logic [7:0]  paddr = 0;
    logic [3:0]  cmd = 0, lanes, fwd_cmd;
    logic [31:0] pwdata = 0, addr = 0, prdata, req_addr, fwd_addr, rd;
    int          errors = 0, checks_done = 0;
    logic [31:0] wins [7] = '{32'h1000, 32'h1fff, 32'h8000_0000, 32'h8fff_ffff,
                              32'h9000_0000, 32'h90ff_ffff, 32'h0502};
    bpdcr_row_t  rows [29] = '{
        {4'h0, 32'h0000_1000, 3'h0, 4'h0}, {4'h1, 32'h0000_1000, 3'h0, 4'h0},
        {4'h2, 32'h0000_1004, 3'h3, 4'h2}, {4'h3, 32'h0000_2000, 3'h0, 4'h0},
        {4'h6, 32'h8000_0010, 3'h3, 4'h6}, {4'h7, 32'h9000_0000, 3'h3, 4'h7},
        {4'h7, 32'h7fff_fffc, 3'h0, 4'h0}, {4'hc, 32'h8000_0000, 3'h3, 4'hc},
        {4'he, 32'h90ff_fffc, 3'h3, 4'he}, {4'hf, 32'h8fff_fffc, 3'h3, 4'hf},
        {4'hd, 32'h8000_0040, 3'h3, 4'hd}, {4'h4, 32'h8000_0000, 3'h0, 4'h0},
        {4'h5, 32'h8000_0000, 3'h0, 4'h0}, {4'h8, 32'h8000_0000, 3'h0, 4'h0},
        {4'h9, 32'h8000_0000, 3'h0, 4'h0}, {4'ha, 32'h0000_0000, 3'h0, 4'h0},
        {4'ha, 32'h0000_0000, 3'h6, 4'h0}, {4'ha, 32'h0000_0100, 3'h4, 4'h0},
        {4'hb, 32'h0000_0000, 3'h6, 4'h0}, {4'ha, 32'h0002_1801, 3'h3, 4'ha},
        {4'ha, 32'h0004_1801, 3'h3, 4'ha}, {4'ha, 32'h0006_0001, 3'h0, 4'h0},
        {4'ha, 32'h0001_0001, 3'h0, 4'h0}, {4'hb, 32'h0002_0801, 3'h3, 4'hb},
        {4'hb, 32'h0005_0801, 3'h3, 4'hb}, {4'hb, 32'h0007_0801, 3'h0, 4'h0},
        {4'hb, 32'h0002_ff01, 3'h3, 4'h1}, {4'hb, 32'h0003_ff01, 3'h3, 4'hb},
        {4'hb, 32'h0009_ff01, 3'h0, 4'h0}};
    always #50 clock = ~clock;
    bpdcr_host host_u (.clock(clock), .go(go), .cmd(cmd), .addr(addr), .idsel(idsel),
        .req_valid(req_valid), .primary_command_lanes(lanes), .req_addr(req_addr),
        .req_idsel(req_idsel));
    bpdcr_decode #(.ADDR_W(32)) dut_u (.clock(clock), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .req_valid(req_valid), .primary_command_lanes(lanes),
        .req_addr(req_addr), .req_idsel(req_idsel), .clock_mask_done(clock_mask_done),
        .dec_done(dec_done), .dec_claim(dec_claim), .dec_internal(dec_internal),
        .fwd_valid(fwd_valid), .fwd_cmd(fwd_cmd), .fwd_addr(fwd_addr), .pri_out_en(pri_out_en),
        .sec_ctl_out_en(sec_ctl_out_en), .sec_bus_rst_n(sec_bus_rst_n), .buf_flush(buf_flush),
        .chip_rst_active(chip_rst_active));
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        if (n >= 20) errors++;
    endtask
    task req(input bpdcr_row_t r, input logic live);
        @(posedge clock);
        go <= 1;
        cmd <= r.cmd;
        addr <= r.addr;
        idsel <= r.flags[2];
        @(posedge clock);
        go <= 0;
        @(posedge clock);
        @(negedge clock);
        chk("dec_done", live, dec_done);
        if (live) begin
            chk("dec_claim", r.flags[1], dec_claim);
            chk("fwd_valid", r.flags[0], fwd_valid);
            chk("dec_internal", r.flags[1] && !r.flags[0], dec_internal);
            chk("fwd_cmd", r.fcmd, fwd_cmd);
            // A Type 1 cycle converted for the secondary bus leaves with type bits zero.
            if (r.flags[0] && r.fcmd != 4'h1)
                chk("fwd_addr", (r.cmd inside {4'ha, 4'hb} && r.addr[23:16] == 8'h02) ?
                    {r.addr[31:2], 2'h0} : r.addr, fwd_addr);
        end
    endtask
    task chip_cycle(input logic early);
        int n;
        clock_mask_done <= early;
        apb(1, `BPDCR_OFF_CTRL, 32'h1);
        apb(0, `BPDCR_OFF_CTRL, 32'h0);
        chk("ctrl", 32'h3, rd);
        apb(0, `BPDCR_OFF_IO_BASE, 32'h0);
        chk("io_base", 32'h0, rd);
        @(negedge clock);
        chk("pri_out_en", 0, pri_out_en);
        chk("sec_bus_rst_n", 0, sec_bus_rst_n);
        req(rows[4], 1'b0);
        apb(1, `BPDCR_OFF_CTRL, 32'h0);
        if (!early) begin
            repeat (25) @(posedge clock);
            @(negedge clock);
            chk("chip_rst_active", 1, chip_rst_active);
            chk("sec_bus_rst_n", 0, sec_bus_rst_n);
            @(posedge clock);
            clock_mask_done <= 1;
        end
        n = 0;
        while (chip_rst_active !== 1'b0 && n < 30) begin
            @(posedge clock);
            n++;
        end
        chk("exit_in_time", 1, n <= 21);
        @(negedge clock);
        chk("sec_bus_rst_n", 1, sec_bus_rst_n);
        chk("pri_out_en", 1, pri_out_en);
        req(rows[16], 1'b1);
    endtask
    task results;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clock);
        nrst <= 1;
        apb(0, `BPDCR_OFF_FUNC_MASK, 32'h0);
        chk("func_mask", 32'h1, rd);
        apb(0, 8'h3c, 32'h0);
        chk("unmapped_err", 1, err);
        for (int i = 0; i < 7; i++)
            apb(1, 8'h08 + 8'(i * 4), wins[i]);
        foreach (rows[i])
            req(rows[i], 1'b1);
        apb(1, `BPDCR_OFF_CTRL, 32'h2);
        repeat (2) @(posedge clock);
        @(negedge clock);
        chk("sec_bus_rst_n", 0, sec_bus_rst_n);
        chk("buf_flush", 1, buf_flush);
        chk("sec_ctl_out_en", 0, sec_ctl_out_en);
        req({4'h6, 32'h8000_0010, 3'h0, 4'h0}, 1'b1);
        req(rows[16], 1'b1);
        apb(1, `BPDCR_OFF_CTRL, 32'h0);
        chip_cycle(1'b0);
        chip_cycle(1'b1);
        // A reset in mid-run must undo a programmed register and restart the pin stage.
        apb(1, `BPDCR_OFF_FUNC_MASK, 32'h3);
        @(posedge clock);
        nrst <= 0;
        repeat (2) @(posedge clock);
        nrst <= 1;
        @(negedge clock);
        chk("rst_pri_out_en", 0, pri_out_en);
        chk("rst_sec_bus_rst_n", 0, sec_bus_rst_n);
        chk("rst_buf_flush", 1, buf_flush);
        @(negedge clock);
        chk("rel_pri_out_en", 1, pri_out_en);
        chk("rel_sec_bus_rst_n", 1, sec_bus_rst_n);
        apb(0, `BPDCR_OFF_FUNC_MASK, 32'h0);
        chk("rst_func_mask", 32'h1, rd);
        results;
    end
    initial begin
        #500000;
        errors++;
        results;
    end
endmodule // tb
`default_nettype wire
